// ==== src/iid_decode.sv ====
`timescale 1ns/1ns
// Operation
// RL1 - Pointer-add adds 6-bit immediate to selected pointer, writes back in one cycle
// RL2 - Pointer-add-and-return adds immediate to third pointer, then loads return-stack top
// RL3 - Pointer-add-and-return takes two cycles; second cycle does nothing
// RL4 - Pointer field value 3 selects add-and-return, always on third pointer
// RL5 - Indexed add sums accumulator and memory at third pointer plus offset up to 95
// RL6 - Indexed add destination bit 0 writes accumulator, 1 writes memory
// RL7 - Indexed bit set sets bit 0..7 at third pointer plus offset, one cycle
// RL8 - Indexed fill writes FFh at third pointer plus offset, flags untouched
// RL9 - Only indexed add updates flags; pointer-add, bit set and fill leave them
module iid_decode
	import iid_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	output logic instr_ready,
	output logic instr_done,
	output logic instr_unsupported,
	output logic [IID_PTR_W-1:0] mem_addr,
	output logic mem_rd_en,
	input wire logic [7:0] mem_rd_data,
	output logic mem_wr_en,
	output logic [7:0] mem_wr_data,
	input wire logic [IID_IP_W-1:0] return_stack_top,
	output logic ip_load,
	output logic [IID_IP_W-1:0] instruction_pointer,
	input wire logic [2:0] ptr_ld_en,
	input wire logic [IID_PTR_W-1:0] ptr_ld_data,
	input wire logic acc_ld_en,
	input wire logic [7:0] acc_ld_data,
	output logic [2:0][IID_PTR_W-1:0] indirect_pointer,
	output logic [7:0] accumulator,
	output logic [4:0] status
);
	// ==========================================================
	// Registers
	iid_state_t state_q;
	logic [1:0] phase_q;
	logic [15:0] instr_q;
	logic [2:0][IID_PTR_W-1:0] ptr_q;
	logic [7:0] acc_q;
	logic [4:0] status_q;
	logic [7:0] result_q;
	logic [4:0] flags_q;
	logic [IID_PTR_W-1:0] mem_addr_q;
	logic mem_rd_en_q;
	logic mem_wr_en_q;
	logic [7:0] mem_wr_data_q;
	logic ip_load_q;
	logic [IID_IP_W-1:0] ip_q;
	logic done_q;
	logic unsup_q;

	iid_alu_if alu_bus ();

	iid_alu u_alu (
		.bus(alu_bus)
	);

	function automatic logic offset_ok(input logic [7:0] ofs);
		offset_ok = (ofs <= IID_OFS_MAX);
	endfunction

	// ==========================================================
	// Decode of the held instruction
	wire st_idle = (state_q == IID_ST_IDLE);
	wire st_exec = (state_q == IID_ST_EXEC);
	wire st_nop = (state_q == IID_ST_NOP);
	wire ph_first = (phase_q == IID_PH_Q1);
	wire ph_read = (phase_q == IID_PH_Q2);
	wire ph_proc = (phase_q == IID_PH_Q3);
	wire ph_last = (phase_q == IID_PH_Q4);
	wire [5:0] k6 = instr_q[5:0];
	wire [7:0] k8 = instr_q[7:0];
	wire ptr_family = (instr_q[15:8] == IID_OP_PTR_ADD);
	wire is_ret = ptr_family && (instr_q[7:6] == IID_RET_SEL); // see RL4
	wire is_ptr = ptr_family && !is_ret;
	wire is_add = (instr_q[15:10] == IID_OP_ACC_ADD) && !instr_q[8] && offset_ok(k8);
	wire is_bset = (instr_q[15:12] == IID_OP_BIT_SET) && !instr_q[8] && offset_ok(k8);
	wire is_fill = (instr_q[15:8] == IID_OP_FILL) && offset_ok(k8);
	wire dest_mem = instr_q[9];
	wire [2:0] bit_sel = instr_q[11:9];
	wire needs_read = is_add || is_bset;
	wire needs_write = (is_add && dest_mem) || is_bset || is_fill;
	wire known = is_ptr || is_ret || is_add || is_bset || is_fill;
	wire [1:0] ptr_sel = is_ret ? IID_THIRD_PTR : instr_q[7:6]; // see RL4
	wire [IID_PTR_W-1:0] ptr_sum = ptr_q[ptr_sel] + {6'h00, k6}; // see RL1
	wire [IID_PTR_W-1:0] idx_addr = ptr_q[IID_THIRD_PTR] + {4'h0, k8}; // see RL5
	wire [7:0] bit_mask = IID_BIT_ONE << bit_sel;
	wire [7:0] result_d = is_fill ? IID_FILL_VAL : // see RL8
		(is_bset ? (mem_rd_data | bit_mask) : alu_bus.sum); // see RL7

	assign alu_bus.a = acc_q;
	assign alu_bus.b = mem_rd_data;

	// ==========================================================
	// Sequencer: Q1 decode, Q2 read, Q3 process, Q4 write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= IID_ST_IDLE;
			phase_q <= IID_PH_Q1;
		end else if (st_idle) begin
			if (instr_valid) begin
				state_q <= IID_ST_EXEC;
			end
			phase_q <= IID_PH_Q1;
		end else if (ph_last) begin
			state_q <= (st_exec && is_ret) ? IID_ST_NOP : IID_ST_IDLE; // see RL3
			phase_q <= IID_PH_Q1;
		end else begin
			phase_q <= phase_q + IID_PH_STEP;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			instr_q <= 16'h0000;
		end else if (st_idle && instr_valid) begin
			instr_q <= instr_word;
		end
	end

	// ==========================================================
	// Data memory port
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem_addr_q <= IID_PTR_RST;
			mem_rd_en_q <= 1'b0;
			mem_wr_en_q <= 1'b0;
			mem_wr_data_q <= 8'h00;
		end else begin
			if (st_exec && ph_first) begin
				mem_addr_q <= idx_addr; // see RL5
			end
			mem_rd_en_q <= st_exec && ph_first && needs_read;
			mem_wr_en_q <= st_exec && ph_proc && needs_write; // see RL6
			if (st_exec && ph_proc) begin
				mem_wr_data_q <= result_d;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			result_q <= 8'h00;
			flags_q <= IID_STAT_RST;
		end else if (st_exec && ph_proc) begin
			result_q <= result_d;
			flags_q <= alu_bus.flags;
		end
	end

	// ==========================================================
	// Indirect pointers
	generate
		for (genvar i = 0; i < 3; i++) begin : g_ptr
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					ptr_q[i] <= IID_PTR_RST;
				end else if (st_exec && ph_last && ptr_family && ptr_sel == 2'(i)) begin
					ptr_q[i] <= ptr_sum; // see RL1, RL2
				end else if (st_idle && ptr_ld_en[i]) begin
					ptr_q[i] <= ptr_ld_data;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Accumulator and status
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			acc_q <= IID_ACC_RST;
		end else if (st_exec && ph_last && is_add && !dest_mem) begin
			acc_q <= result_q; // see RL6
		end else if (st_idle && acc_ld_en) begin
			acc_q <= acc_ld_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_q <= IID_STAT_RST;
		end else if (st_exec && ph_last && is_add) begin
			status_q <= flags_q; // see RL9
		end
	end

	// ==========================================================
	// Return and completion
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ip_load_q <= 1'b0;
			ip_q <= IID_IP_RST;
			done_q <= 1'b0;
			unsup_q <= 1'b0;
		end else begin
			ip_load_q <= st_exec && ph_last && is_ret; // see RL2
			if (st_exec && ph_last && is_ret) begin
				ip_q <= return_stack_top;
			end
			done_q <= ph_last && ((st_exec && !is_ret) || st_nop); // see RL3
			unsup_q <= st_exec && ph_last && !known;
		end
	end

	assign instr_ready = st_idle;
	assign instr_done = done_q;
	assign instr_unsupported = unsup_q;
	assign mem_addr = mem_addr_q;
	assign mem_rd_en = mem_rd_en_q;
	assign mem_wr_en = mem_wr_en_q;
	assign mem_wr_data = mem_wr_data_q;
	assign ip_load = ip_load_q;
	assign instruction_pointer = ip_q;
	assign indirect_pointer = ptr_q;
	assign accumulator = acc_q;
	assign status = status_q;

	// ==========================================================
	// Checks
	AST_PTR_ADD: assert property (@(posedge clk) disable iff (sys_rst) // see RL1
		(st_exec && ph_first && is_ptr) |-> ##4 (ptr_q[ptr_sel] == $past(ptr_sum, 4)))
		else $error("pointer add result wrong");
	AST_RET_LOAD: assert property (@(posedge clk) disable iff (sys_rst) // see RL2
		(st_exec && ph_first && is_ret) |-> ##4
		(ip_load && instruction_pointer == $past(return_stack_top, 1)))
		else $error("return did not load instruction pointer");
	AST_RET_NOP: assert property (@(posedge clk) disable iff (sys_rst) // see RL3
		(st_exec && ph_first && is_ret) |-> ##4
		(st_nop && !mem_wr_en && !mem_rd_en && !instr_done)[*4] ##1 instr_done)
		else $error("return second cycle not idle");
	AST_RET_PTR2: assert property (@(posedge clk) disable iff (sys_rst) // see RL4
		(st_exec && ph_first && is_ret) |-> ##4
		(ptr_q[IID_THIRD_PTR] == $past(ptr_q[IID_THIRD_PTR], 4) + {6'h00, k6}))
		else $error("return did not update third pointer");
	AST_IDX_ADDR: assert property (@(posedge clk) disable iff (sys_rst) // see RL5
		(st_exec && ph_first && (is_add || is_bset || is_fill)) |=>
		(mem_addr == ptr_q[IID_THIRD_PTR] + {4'h0, instr_q[7:0]}))
		else $error("indexed address wrong");
	AST_RD_PHASE: assert property (@(posedge clk) disable iff (sys_rst) // see RL5
		mem_rd_en |-> (st_exec && ph_read && needs_read))
		else $error("memory read strobe outside read phase");
	AST_ADD_MEM: assert property (@(posedge clk) disable iff (sys_rst) // see RL6
		(st_exec && ph_first && is_add && dest_mem) |-> ##3
		(mem_wr_en && mem_wr_data == 8'($past(acc_q, 3) + $past(mem_rd_data, 1))))
		else $error("indexed add to memory wrong");
	AST_ADD_ACC: assert property (@(posedge clk) disable iff (sys_rst) // see RL6
		(st_exec && ph_first && is_add && !dest_mem) |-> ##3 !mem_wr_en ##1
		(acc_q == 8'($past(acc_q, 4) + $past(mem_rd_data, 2))))
		else $error("indexed add to accumulator wrong");
	AST_BIT_SET: assert property (@(posedge clk) disable iff (sys_rst) // see RL7
		(st_exec && ph_first && is_bset) |-> ##3 (mem_wr_en && mem_wr_data[bit_sel] &&
		((mem_wr_data & ~bit_mask) == ($past(mem_rd_data, 1) & ~bit_mask))))
		else $error("indexed bit set wrong");
	AST_FILL: assert property (@(posedge clk) disable iff (sys_rst) // see RL8
		(st_exec && ph_first && is_fill) |-> ##3 (mem_wr_en && mem_wr_data == IID_FILL_VAL))
		else $error("indexed fill wrong");
	AST_FLAGS_KEEP: assert property (@(posedge clk) disable iff (sys_rst) // see RL9
		(st_exec && ph_first && !is_add) |-> ##4 (status == $past(status, 4)))
		else $error("flags changed by non-add");
endmodule

// ==== src/iid_pkg.sv ====
// ==========================================================
// Shared constants for the indexed instruction decoder
package iid_pkg;
	localparam int IID_PTR_W = 12;
	localparam int IID_IP_W = 21;

	// ==========================================================
	// Opcode fields
	localparam logic [7:0] IID_OP_PTR_ADD = 8'he8;
	localparam logic [5:0] IID_OP_ACC_ADD = 6'h09;
	localparam logic [3:0] IID_OP_BIT_SET = 4'h8;
	localparam logic [7:0] IID_OP_FILL = 8'h68;
	localparam logic [1:0] IID_RET_SEL = 2'h3;
	localparam logic [1:0] IID_THIRD_PTR = 2'h2;
	localparam logic [7:0] IID_OFS_MAX = 8'h5f;
	localparam logic [7:0] IID_FILL_VAL = 8'hff;
	localparam logic [7:0] IID_BIT_ONE = 8'h01;

	// ==========================================================
	// Phases of one instruction cycle
	localparam logic [1:0] IID_PH_Q1 = 2'h0;
	localparam logic [1:0] IID_PH_Q2 = 2'h1;
	localparam logic [1:0] IID_PH_Q3 = 2'h2;
	localparam logic [1:0] IID_PH_Q4 = 2'h3;
	localparam logic [1:0] IID_PH_STEP = 2'h1;

	// ==========================================================
	// Status flag positions and reset values
	localparam int IID_FLG_C = 0;
	localparam int IID_FLG_DC = 1;
	localparam int IID_FLG_Z = 2;
	localparam int IID_FLG_OV = 3;
	localparam int IID_FLG_N = 4;
	localparam logic [IID_PTR_W-1:0] IID_PTR_RST = 12'h000;
	localparam logic [7:0] IID_ACC_RST = 8'h00;
	localparam logic [4:0] IID_STAT_RST = 5'h00;
	localparam logic [IID_IP_W-1:0] IID_IP_RST = 21'h000000;

	typedef enum logic [2:0] {
		IID_ST_IDLE = 3'b001,
		IID_ST_EXEC = 3'b010,
		IID_ST_NOP = 3'b100
	} iid_state_t;
endpackage

// ==== src/iid_alu_if.sv ====
`timescale 1ns/1ns
// ==========================================================
// Operands and result of the byte adder
interface iid_alu_if;
	logic [7:0] a;
	logic [7:0] b;
	logic [7:0] sum;
	logic [4:0] flags;
	modport core (output a, output b, input sum, input flags);
	modport alu (input a, input b, output sum, output flags);
endinterface

// ==== src/iid_alu.sv ====
`timescale 1ns/1ns
// ==========================================================
// Byte adder with status flags
module iid_alu
	import iid_pkg::*;
(
	iid_alu_if.alu bus
);
	logic [8:0] full_sum;
	logic [4:0] nib_sum;

	assign full_sum = {1'b0, bus.a} + {1'b0, bus.b};
	assign nib_sum = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
	assign bus.sum = full_sum[7:0];
	assign bus.flags[IID_FLG_C] = full_sum[8];
	assign bus.flags[IID_FLG_DC] = nib_sum[4];
	assign bus.flags[IID_FLG_Z] = (full_sum[7:0] == 8'h00);
	// Signed overflow: like-signed operands, differently signed sum
	assign bus.flags[IID_FLG_OV] = (bus.a[7] == bus.b[7]) && (full_sum[7] != bus.a[7]);
	assign bus.flags[IID_FLG_N] = full_sum[7];
endmodule

// ==== sim/iid_decode_tb.sv ====
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module iid_decode_tb;
	import iid_pkg::*;
	logic clk, sys_rst, instr_valid, instr_ready, instr_done, instr_unsupported;
	logic [15:0] instr_word;
	logic [IID_PTR_W-1:0] mem_addr, ptr_ld_data, wr_addr, rd_addr;
	logic mem_rd_en, mem_wr_en, ip_load, acc_ld_en;
	logic [7:0] mem_rd_data, mem_wr_data, acc_ld_data, accumulator, mem_val, wr_data;
	logic [IID_IP_W-1:0] return_stack_top, instruction_pointer;
	logic [2:0] ptr_ld_en;
	logic [2:0][IID_PTR_W-1:0] indirect_pointer;
	logic [4:0] status;
	logic [1:0] rd_hold;
	int n_errors, total_checks, rd_cnt, wr_cnt, ipl_cnt, cyc_cnt;

	iid_decode iid_decode_inst (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready), .instr_done(instr_done),
		.instr_unsupported(instr_unsupported), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
		.mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
		.return_stack_top(return_stack_top), .ip_load(ip_load),
		.instruction_pointer(instruction_pointer), .ptr_ld_en(ptr_ld_en),
		.ptr_ld_data(ptr_ld_data), .acc_ld_en(acc_ld_en), .acc_ld_data(acc_ld_data),
		.indirect_pointer(indirect_pointer), .accumulator(accumulator), .status(status));

	// ==========================================================
	// Clock, memory responder and strobe capture
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Read data valid for two cycles after the strobe, then scrambled
	always @(negedge clk) begin
		if (mem_rd_en) begin
			mem_rd_data <= mem_val;
			rd_addr <= mem_addr;
			rd_hold <= 2'h2;
			rd_cnt <= rd_cnt + 1;
		end else if (rd_hold != 2'h0) begin
			rd_hold <= rd_hold - 2'h1;
		end else begin
			mem_rd_data <= ~mem_val;
		end
	end
	always @(posedge clk) begin
		cyc_cnt++;
		if (mem_wr_en) begin
			wr_addr <= mem_addr;
			wr_data <= mem_wr_data;
			wr_cnt <= wr_cnt + 1;
		end
		if (ip_load)
			ipl_cnt <= ipl_cnt + 1;
		if (cyc_cnt == 3000) begin
			n_errors++;
			end_of_test();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic load(input logic [2:0] pe, input logic [11:0] pd, input logic [7:0] ad);
		@(negedge clk);
		ptr_ld_en = pe;
		ptr_ld_data = pd;
		acc_ld_en = 1'b1;
		acc_ld_data = ad;
		@(negedge clk);
		ptr_ld_en = 3'h0;
		acc_ld_en = 1'b0;
	endtask
	task automatic run(input logic [15:0] w, output int cyc);
		@(negedge clk);
		instr_word = w;
		instr_valid = 1'b1;
		@(negedge clk);
		instr_valid = 1'b0;
		cyc = 1;
		while (instr_done !== 1'b1 && cyc < 20) begin
			@(negedge clk);
			cyc++;
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_ptr_add();
		int c;
		for (int f = 0; f < 3; f++) begin
			load(3'h1 << f, 12'h3ff, 8'h00);
			run({IID_OP_PTR_ADD, 2'(f), 6'h3f}, c);
			`CHK("ptr add cycles", 5, c)
			`CHK("ptr sum", 12'h43e, indirect_pointer[f])
			`CHK("ptr flags", 5'h07, status)
		end
	endtask
	task automatic t_return();
		int c, r0, w0, i0;
		load(3'h4, 12'h3ff, 8'h00);
		return_stack_top = 21'h0abcde;
		r0 = rd_cnt;
		w0 = wr_cnt;
		i0 = ipl_cnt;
		run({IID_OP_PTR_ADD, IID_RET_SEL, 6'h23}, c);
		`CHK("ret cycles", 9, c)
		`CHK("ret ptr", 12'h422, indirect_pointer[2])
		`CHK("ret ptr0", 12'h43e, indirect_pointer[0])
		`CHK("ret ip", 21'h0abcde, instruction_pointer)
		`CHK("ret loads", i0 + 1, ipl_cnt)
		`CHK("ret mem", r0 + w0, rd_cnt + wr_cnt)
		`CHK("ret flags", 5'h07, status)
	endtask
	task automatic t_acc_add();
		int c;
		load(3'h4, 12'ha00, 8'h88);
		mem_val = 8'h88;
		run({IID_OP_ACC_ADD, 1'b0, 1'b0, IID_OFS_MAX}, c);
		`CHK("add rd addr", 12'ha5f, rd_addr)
		`CHK("add acc", 8'h10, accumulator)
		`CHK("add flags", 5'h0b, status)
		load(3'h0, 12'h000, 8'h7f);
		mem_val = 8'h81;
		run({IID_OP_ACC_ADD, 1'b1, 1'b0, 8'h2c}, c);
		`CHK("add wr", {12'ha2c, 8'h00}, {wr_addr, wr_data})
		`CHK("add acc kept", 8'h7f, accumulator)
		`CHK("add flags z", 5'h07, status)
	endtask
	task automatic t_bit_fill();
		int c, w0;
		load(3'h4, 12'ha00, 8'h00);
		mem_val = 8'h55;
		run({IID_OP_BIT_SET, 3'h7, 1'b0, 8'h0a}, c);
		`CHK("bit cycles", 5, c)
		`CHK("bit unsup", 1'b0, instr_unsupported)
		`CHK("bit wr", {12'ha0a, 8'hd5}, {wr_addr, wr_data})
		`CHK("bit flags", 5'h07, status)
		run({IID_OP_FILL, 8'h2c}, c);
		`CHK("fill wr", {12'ha2c, IID_FILL_VAL}, {wr_addr, wr_data})
		`CHK("fill flags", 5'h07, status)
		w0 = wr_cnt;
		run({IID_OP_FILL, 8'h60}, c);
		`CHK("fill bad ofs", 1'b1, instr_unsupported)
		`CHK("fill bad no wr", w0, wr_cnt)
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		mem_rd_data = 8'h00;
		mem_val = 8'h00;
		rd_hold = 2'h0;
		return_stack_top = 21'h000000;
		ptr_ld_en = 3'h0;
		ptr_ld_data = 12'h000;
		acc_ld_en = 1'b0;
		acc_ld_data = 8'h00;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		`CHK("rst ready", 1'b1, instr_ready)
		`CHK("rst state", 26'h0, {indirect_pointer[2], accumulator, status, ip_load})
		load(3'h0, 12'h000, 8'h00);
		t_acc_add();
		t_ptr_add();
		t_return();
		t_bit_fill();
		end_of_test();
	end
endmodule
